// file: mif_pkg.sv
// Purpose: Shared constants for the timer, EEPROM and low-voltage flag block
// Assumes: APB slave with 8-bit byte addresses and 32-bit data
// Notes:   Source index 0..5 is timer zero P, timer zero A, timer one P,
//          timer one A, low-voltage detector, data EEPROM
package mif_pkg;

    // Bus geometry
    localparam int unsigned ADDR_W  = 8;
    localparam int unsigned DATA_W  = 32;
    localparam int unsigned REG_W   = 8;
    localparam int unsigned NUM_SRC = 6;

    // Register byte offsets
    localparam logic [7:0] OFS_TIMER_FLAGS  = 8'h00;
    localparam logic [7:0] OFS_EE_LV_FLAGS  = 8'h04;
    localparam logic [7:0] OFS_GLOBAL_CTRL  = 8'h08;
    localparam logic [7:0] OFS_IRQ_STATUS   = 8'h0C;
    localparam logic [7:0] OFS_IRQ_MASK     = 8'h10;

    // Timer register: flags in the high nibble, enables in the low one
    localparam int unsigned TMR_FLAG_LSB    = 4;
    localparam int unsigned TMR_EN_LSB      = 0;
    localparam int unsigned TMR_SRC_CNT     = 4;

    // EEPROM / low-voltage register fields
    localparam int unsigned EL_FLAG_LSB     = 4;
    localparam int unsigned EL_EN_LSB       = 0;
    localparam int unsigned EL_SRC_CNT      = 2;

    // Global control register fields
    localparam int unsigned GIE_BIT         = 0;
    localparam int unsigned STACK_FULL_BIT  = 1;

    // Values after reset
    localparam logic [7:0] RST_FLAG_REG     = 8'h00;
    localparam logic [5:0] RST_SRC_VEC      = 6'h00;
    localparam logic       RST_BIT          = 1'b0;
    localparam logic [31:0] RST_RDATA       = 32'h00000000;

endpackage

// file: mif_src_slot.sv
// Purpose: One interrupt source: request flag, enable bit, gated request
// Assumes: Event input is a one-cycle or level pulse in the core clock domain
// Notes:   Hardware set beats a software write in the same cycle
`timescale 1ns/1ps
module mif_src_slot (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic src_event,
    input  wire logic wr,
    input  wire logic wd_flag,
    input  wire logic wd_enable,
    input  wire logic gate,
    output logic      flag,
    output logic      enable,
    output logic      request
);

    // Request flag; a late event is never lost to a software clear
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flag <= mif_pkg::RST_BIT;
        end else if (src_event) begin
            flag <= 1'b1;
        end else if (wr) begin
            flag <= wd_flag;
        end
    end

    // Individual enable, plain read/write storage
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            enable <= mif_pkg::RST_BIT;
        end else if (wr) begin
            enable <= wd_enable;
        end
    end

    // Pending flag reaches the sequencer only when enabled and gated
    assign request = flag & enable & gate;

    a_set_wins: assert property (@(posedge core_clk) disable iff (rst)
        src_event |=> flag)
        else $error("flag lost an event to a same-cycle write");

endmodule

// file: mif_irq_flags.sv
// Purpose: Flag and enable registers for timer, EEPROM and low-voltage irqs
// Assumes: APB master per the bus spec; event inputs synchronous to core_clk
// Notes:   Zero wait states; unmapped offsets answer with pslverr
//
// Overview of operation
// - Timer one compare A sets bit 7
// - Timer one compare P sets bit 6
// - Timer zero compare A sets bit 5
// - Timer zero compare P sets bit 4
// - Bit 3 enables timer one compare A
// - Bit 2 enables timer one compare P
// - Bit 1 enables timer zero compare A
// - Bit 0 enables timer zero compare P
// - EEPROM event sets second register bit 5
// - Low-voltage event sets second register bit 4
// - Second register bit 1 enables EEPROM
// - Second register bit 0 enables low-voltage
// - Second register bits 7-6, 3-2 read zero
// - Flag requests only when its enable set
// - Global enable clear blocks every request
`timescale 1ns/1ps
module mif_irq_flags (
    input  wire logic        core_clk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Source events
    input  wire logic        timer_one_cmp_a_match,
    input  wire logic        timer_one_cmp_p_match,
    input  wire logic        timer_zero_cmp_a_match,
    input  wire logic        timer_zero_cmp_p_match,
    input  wire logic        eeprom_irq_event,
    input  wire logic        low_voltage_detector_event,
    // Interrupt sequencer side
    input  wire logic        stack_full,
    input  wire logic        irq_ack,
    output logic      [5:0]  src_irq_req,
    output logic             irq
);

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    logic       access;
    logic       setup;
    logic       wr_acc;
    logic       hit_tmr;
    logic       hit_el;
    logic       hit_ctrl;
    logic       hit_stat;
    logic       hit_mask;
    logic       mapped;
    logic       global_irq_enable;
    logic       gate;
    logic [5:0] src_event;
    logic [5:0] wr_src;
    logic [5:0] wd_flag;
    logic [5:0] wd_enable;
    logic [5:0] flag;
    logic [5:0] enable;
    logic [5:0] irq_status;
    logic [5:0] next_irq_status;
    logic [5:0] irq_mask;
    logic [7:0] tmr_reg;
    logic [7:0] el_reg;
    logic [31:0] rd_mux;

    // APB phase decode
    assign setup  = psel & ~penable;
    assign access = psel & penable;
    assign wr_acc = access & pwrite & mapped;

    // Address decode; only whole aligned words are mapped
    assign hit_tmr  = (paddr == mif_pkg::OFS_TIMER_FLAGS);
    assign hit_el   = (paddr == mif_pkg::OFS_EE_LV_FLAGS);
    assign hit_ctrl = (paddr == mif_pkg::OFS_GLOBAL_CTRL);
    assign hit_stat = (paddr == mif_pkg::OFS_IRQ_STATUS);
    assign hit_mask = (paddr == mif_pkg::OFS_IRQ_MASK);
    assign mapped   = hit_tmr | hit_el | hit_ctrl | hit_stat | hit_mask;

    // Never stalls: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;

    // Source events in slot order
    assign src_event = {eeprom_irq_event,
                        low_voltage_detector_event,
                        timer_one_cmp_a_match,
                        timer_one_cmp_p_match,
                        timer_zero_cmp_a_match,
                        timer_zero_cmp_p_match};

    // Write fan-out: low four slots live in the timer register
    assign wr_src = {{mif_pkg::EL_SRC_CNT{wr_acc & hit_el}},
                     {mif_pkg::TMR_SRC_CNT{wr_acc & hit_tmr}}};

    // Write data per slot; unimplemented lanes of the second register dropped
    assign wd_flag = {pwdata[mif_pkg::EL_FLAG_LSB+1:mif_pkg::EL_FLAG_LSB],
                      pwdata[mif_pkg::TMR_FLAG_LSB+3:mif_pkg::TMR_FLAG_LSB]};
    assign wd_enable = {pwdata[mif_pkg::EL_EN_LSB+1:mif_pkg::EL_EN_LSB],
                        pwdata[mif_pkg::TMR_EN_LSB+3:mif_pkg::TMR_EN_LSB]};

    // A full stack holds requests back until it has room again
    assign gate = global_irq_enable & ~stack_full;

    // One slot per source
    genvar gi;
    generate
        for (gi = 0; gi < mif_pkg::NUM_SRC; gi++) begin : g_src
            mif_src_slot u_slot (
                .core_clk  (core_clk),
                .rst       (rst),
                .src_event (src_event[gi]),
                .wr        (wr_src[gi]),
                .wd_flag   (wd_flag[gi]),
                .wd_enable (wd_enable[gi]),
                .gate      (gate),
                .flag      (flag[gi]),
                .enable    (enable[gi]),
                .request   (src_irq_req[gi])
            );
        end
    endgenerate

    // Register views
    assign tmr_reg = {flag[3:0], enable[3:0]};
    assign el_reg  = {2'b00, flag[5:4], 2'b00, enable[5:4]};

    // Global enable: servicing clears it, so ack beats a software set
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            global_irq_enable <= mif_pkg::RST_BIT;
        end else if (irq_ack) begin
            global_irq_enable <= 1'b0;
        end else if (wr_acc && hit_ctrl) begin
            global_irq_enable <= pwdata[mif_pkg::GIE_BIT];
        end
    end

    // Sticky status of requests taken; write one clears, new request wins
    always_comb begin
        next_irq_status = irq_status;
        if (wr_acc && hit_stat) begin
            next_irq_status = irq_status & ~pwdata[5:0];
        end
        next_irq_status = next_irq_status | src_irq_req;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_status <= mif_pkg::RST_SRC_VEC;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    // Mask, same layout as status
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_mask <= mif_pkg::RST_SRC_VEC;
        end else if (wr_acc && hit_mask) begin
            irq_mask <= pwdata[5:0];
        end
    end

    // Level interrupt; drops only once software clears the status bit or its mask bit
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq <= mif_pkg::RST_BIT;
        end else begin
            irq <= |(next_irq_status & irq_mask);
        end
    end

    // Read mux; unmapped offsets read as zero
    always_comb begin
        rd_mux = mif_pkg::RST_RDATA;
        case (1'b1)
            hit_tmr:  rd_mux[7:0] = tmr_reg;
            hit_el:   rd_mux[7:0] = el_reg;
            hit_ctrl: begin
                rd_mux[mif_pkg::GIE_BIT]        = global_irq_enable;
                rd_mux[mif_pkg::STACK_FULL_BIT] = stack_full;
            end
            hit_stat: rd_mux[5:0] = irq_status;
            hit_mask: rd_mux[5:0] = irq_mask;
            default:  rd_mux = mif_pkg::RST_RDATA;
        endcase
    end

    // Read data captured in setup so it stands from a flop in access.
    // Trade-off: a flag set during the access cycle shows on the next read.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prdata <= mif_pkg::RST_RDATA;
        end else if (setup && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    // Bus write and read sequences
    sequence s_wr_tmr;
        psel && penable && pwrite && hit_tmr;
    endsequence

    sequence s_wr_el;
        psel && penable && pwrite && hit_el;
    endsequence

    sequence s_rd_el;
        psel && !penable && !pwrite && hit_el ##1 psel && penable;
    endsequence

    sequence s_rd_tmr;
        psel && !penable && !pwrite && hit_tmr ##1 psel && penable;
    endsequence

    // Timer flag setting
    a_t1a_set: assert property (
        timer_one_cmp_a_match |=> tmr_reg[7] [*1] ##1 1'b1)
        else $error("timer one A flag not set");

    a_t1p_set: assert property (
        timer_one_cmp_p_match |=> tmr_reg[6])
        else $error("timer one P flag not set");

    a_t0a_set: assert property (
        timer_zero_cmp_a_match |=> tmr_reg[5])
        else $error("timer zero A flag not set");

    a_t0p_set: assert property (
        timer_zero_cmp_p_match |=> tmr_reg[4])
        else $error("timer zero P flag not set");

    // Enable writes land in the low nibble
    a_tmr_en_wr: assert property (
        s_wr_tmr |=> tmr_reg[3:0] == $past(pwdata[3:0]))
        else $error("timer enables not written");

    a_t0p_en_only: assert property (
        s_wr_tmr ##1 !timer_zero_cmp_p_match [*2]
        |-> tmr_reg[4] == 1'b0 || $past(tmr_reg[4]))
        else $error("timer zero P flag set without event");

    // Second register
    a_ee_set: assert property (
        eeprom_irq_event |=> el_reg[5])
        else $error("EEPROM flag not set");

    a_lv_set: assert property (
        low_voltage_detector_event |=> el_reg[4])
        else $error("low-voltage flag not set");

    a_el_en_wr: assert property (
        s_wr_el |=> el_reg[1:0] == $past(pwdata[1:0]))
        else $error("EEPROM/low-voltage enables not written");

    a_el_rsvd_rd: assert property (
        s_rd_el |-> prdata[7:6] == 2'b00 && prdata[3:2] == 2'b00)
        else $error("reserved bits read nonzero");

    // Software clear takes effect when no event races it
    a_sw_clear: assert property (
        s_wr_tmr ##0 !pwdata[7] && !timer_one_cmp_a_match
        |=> !tmr_reg[7])
        else $error("flag not cleared by software");

    // Requests need flag, enable and global enable together
    a_req_gated: assert property (
        (src_irq_req & ~(flag & enable)) == 6'h00)
        else $error("request without enabled flag");

    a_gie_block: assert property (
        !global_irq_enable || stack_full |-> src_irq_req == 6'h00)
        else $error("request while globally blocked");

    a_ack_drops: assert property (
        irq_ack |=> !global_irq_enable ##1 1'b1)
        else $error("ack did not clear global enable");

    // Interrupt line follows unmasked taken requests within one cycle
    a_irq_follow: assert property (
        (src_irq_req & irq_mask) != 6'h00 |=> irq)
        else $error("unmasked request missed interrupt");

    // With the gate open, each enable bit steers its own set flag to the sequencer
    a_t1a_en_gate: assert property (
        tmr_reg[7] && gate |-> src_irq_req[3] == tmr_reg[3])
        else $error("timer one A request not steered by its enable");

    a_t1p_en_gate: assert property (
        tmr_reg[6] && gate |-> src_irq_req[2] == tmr_reg[2])
        else $error("timer one P request not steered by its enable");

    a_t0a_en_gate: assert property (
        tmr_reg[5] && gate |-> src_irq_req[1] == tmr_reg[1])
        else $error("timer zero A request not steered by its enable");

    a_t0p_en_gate: assert property (
        tmr_reg[4] && gate |-> src_irq_req[0] == tmr_reg[0])
        else $error("timer zero P request not steered by its enable");

    a_ee_en_gate: assert property (
        el_reg[5] && gate |-> src_irq_req[5] == el_reg[1])
        else $error("EEPROM request not steered by its enable");

    a_lv_en_gate: assert property (
        el_reg[4] && gate |-> src_irq_req[4] == el_reg[0])
        else $error("low-voltage request not steered by its enable");

    // Status: a taken request always lands, a one clears an idle bit
    a_stat_set: assert property (
        src_irq_req != 6'h00 |=> (irq_status & $past(src_irq_req)) == $past(src_irq_req))
        else $error("taken request missing from status");

    a_stat_w1c: assert property (
        wr_acc && hit_stat && pwdata[0] && !src_irq_req[0] |=> !irq_status[0])
        else $error("status bit not cleared by a write of one");

    // A refused write must leave every writable bit alone
    a_unmapped_wr: assert property (
        psel && penable && pwrite && !mapped
        |=> $stable(tmr_reg[3:0]) && $stable(el_reg[1:0]) && $stable(irq_mask))
        else $error("refused write changed a register");

    // Read data moves only after a read setup, so it stands through access
    a_rdata_holds: assert property (
        !(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved outside a read setup");

    a_rd_tmr_view: assert property (
        s_rd_tmr |-> prdata == {24'h000000, $past(tmr_reg)})
        else $error("timer register read back wrong");

    // Software write of the global enable lands unless an ack races it
    a_gie_write: assert property (
        wr_acc && hit_ctrl && !irq_ack |=> global_irq_enable == $past(pwdata[0]))
        else $error("global enable write lost");

    // Clean start
    a_reset_zero: assert property (
        $fell(rst) |-> flag == 6'h00 && enable == 6'h00 && !irq)
        else $error("state not zero after reset");

endmodule

// file: tb_multi_function_irq_flags.sv
// Purpose: Self-checking bench for the timer, EEPROM and low-voltage flags
// Assumes: Zero-wait APB slave; events are one-cycle pulses on core_clk
// Notes:   Source order 0..5 is t0P, t0A, t1P, t1A, low-voltage, EEPROM
`timescale 1ns/1ps
module tb_multi_function_irq_flags;
    logic        core_clk    = 1'b0;
    logic        rst         = 1'b1;
    logic        psel        = 1'b0;
    logic        penable     = 1'b0;
    logic        pwrite      = 1'b0;
    logic [7:0]  paddr       = 8'h00;
    logic [31:0] pwdata      = 32'h00000000;
    logic [5:0]  ev          = 6'h00;
    logic        stack_full  = 1'b0;
    logic        irq_ack     = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [5:0]  src_irq_req;
    logic        irq;
    logic [31:0] rd;
    logic        err;
    logic [7:0]  a;
    logic [31:0] fb;
    logic [31:0] eb;
    int          n_mismatch  = 0;
    int          checks_done = 0;

    // 200 MHz core clock
    always #2.5 core_clk = ~core_clk;

    mif_irq_flags DUT (
        .core_clk                   (core_clk),
        .rst                        (rst),
        .psel                       (psel),
        .penable                    (penable),
        .pwrite                     (pwrite),
        .paddr                      (paddr),
        .pwdata                     (pwdata),
        .prdata                     (prdata),
        .pready                     (pready),
        .pslverr                    (pslverr),
        .timer_one_cmp_a_match      (ev[3]),
        .timer_one_cmp_p_match      (ev[2]),
        .timer_zero_cmp_a_match     (ev[1]),
        .timer_zero_cmp_p_match     (ev[0]),
        .eeprom_irq_event           (ev[5]),
        .low_voltage_detector_event (ev[4]),
        .stack_full                 (stack_full),
        .irq_ack                    (irq_ack),
        .src_irq_req                (src_irq_req),
        .irq                        (irq)
    );

    // Verdict and end of run, shared with the watchdog
    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Case-equality compare so an unknown never matches
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; entered just after an edge, leaves one idle edge
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= ad;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        // No fixed latency assumed; the watchdog bounds this wait
        while (pready !== 1'b1) begin
            @(posedge core_clk);
        end
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic wreg(input logic [7:0] ad, input logic [31:0] d);
        apb(1'b1, ad, d);
    endtask

    task automatic rchk(input logic [7:0] ad, input logic [31:0] exp);
        apb(1'b0, ad, 32'h00000000);
        check(rd, exp);
    endtask

    // One-cycle event; returns once the flag has settled
    task automatic pulse(input int i);
        ev <= 6'h01 << i;
        @(posedge core_clk);
        ev <= 6'h00;
        @(posedge core_clk);
    endtask

    // Watchdog: the sequence needs well under a thousand cycles
    initial begin
        #20000;
        n_mismatch++;
        end_sim();
    end

    // Main sequence
    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        check(irq, 32'h00000000);
        check(src_irq_req, 32'h00000000);
        check(pready, 32'h00000001);
        rchk(mif_pkg::OFS_TIMER_FLAGS, 32'h00000000);
        rchk(mif_pkg::OFS_EE_LV_FLAGS, 32'h00000000);
        rchk(mif_pkg::OFS_GLOBAL_CTRL, 32'h00000000);
        rchk(mif_pkg::OFS_IRQ_STATUS, 32'h00000000);
        rchk(mif_pkg::OFS_IRQ_MASK, 32'h00000000);
        wreg(mif_pkg::OFS_TIMER_FLAGS, 32'hFFFFFFFF);
        rchk(mif_pkg::OFS_TIMER_FLAGS, 32'h000000FF);
        wreg(mif_pkg::OFS_EE_LV_FLAGS, 32'hFFFFFFFF);
        rchk(mif_pkg::OFS_EE_LV_FLAGS, 32'h00000033);
        wreg(mif_pkg::OFS_TIMER_FLAGS, 32'h00000000);
        wreg(mif_pkg::OFS_EE_LV_FLAGS, 32'h00000000);
        rchk(mif_pkg::OFS_EE_LV_FLAGS, 32'h00000000);
        // Unmapped offset is refused and reads zero
        apb(1'b0, 8'h20, 32'h00000000);
        check({31'h0, err}, 32'h00000001);
        check(rd, 32'h00000000);
        wreg(mif_pkg::OFS_GLOBAL_CTRL, 32'h00000001);
        // Each source in turn: set, request, mask, then software clear
        for (int i = 0; i < 6; i++) begin
            a  = (i < 4) ? mif_pkg::OFS_TIMER_FLAGS : mif_pkg::OFS_EE_LV_FLAGS;
            eb = 32'h00000001 << ((i < 4) ? i : i - 4);
            fb = eb << 4;
            wreg(mif_pkg::OFS_IRQ_MASK, 32'h00000001 << i);
            wreg(a, eb);
            pulse(i);
            check(src_irq_req, 32'h00000001 << i);
            rchk(a, fb | eb);
            rchk(mif_pkg::OFS_IRQ_STATUS, 32'h00000001 << i);
            check(irq, 32'h00000001);
            wreg(a, fb);
            check(src_irq_req, 32'h00000000);
            rchk(a, fb);
            wreg(mif_pkg::OFS_IRQ_STATUS, 32'h00000001 << i);
            wreg(a, 32'h00000000);
            rchk(a, 32'h00000000);
            rchk(mif_pkg::OFS_IRQ_STATUS, 32'h00000000);
            check(irq, 32'h00000000);
        end
        // Global blocking: stack full, sequencer ack, software clear
        wreg(mif_pkg::OFS_TIMER_FLAGS, 32'h00000011);
        check(src_irq_req, 32'h00000001);
        stack_full <= 1'b1;
        @(posedge core_clk);
        check(src_irq_req, 32'h00000000);
        rchk(mif_pkg::OFS_GLOBAL_CTRL, 32'h00000003);
        stack_full <= 1'b0;
        irq_ack    <= 1'b1;
        @(posedge core_clk);
        irq_ack <= 1'b0;
        @(posedge core_clk);
        check(src_irq_req, 32'h00000000);
        rchk(mif_pkg::OFS_GLOBAL_CTRL, 32'h00000000);
        wreg(mif_pkg::OFS_GLOBAL_CTRL, 32'h00000001);
        check(src_irq_req, 32'h00000001);
        wreg(mif_pkg::OFS_GLOBAL_CTRL, 32'h00000000);
        check(src_irq_req, 32'h00000000);
        rchk(mif_pkg::OFS_TIMER_FLAGS, 32'h00000011);
        // An event in the very access edge of a clearing write still sets
        fork
            wreg(mif_pkg::OFS_TIMER_FLAGS, 32'h00000000);
            begin
                @(posedge core_clk);
                ev <= 6'h08;
                @(posedge core_clk);
                ev <= 6'h00;
            end
        join
        rchk(mif_pkg::OFS_TIMER_FLAGS, 32'h00000080);
        // Reset in mid-run must drop state that is really set
        wreg(mif_pkg::OFS_GLOBAL_CTRL, 32'h00000001);
        wreg(mif_pkg::OFS_IRQ_MASK, 32'h00000001);
        rchk(mif_pkg::OFS_IRQ_STATUS, 32'h00000001);
        check(irq, 32'h00000001);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        check(irq, 32'h00000000);
        rchk(mif_pkg::OFS_TIMER_FLAGS, 32'h00000000);
        rchk(mif_pkg::OFS_GLOBAL_CTRL, 32'h00000000);
        rchk(mif_pkg::OFS_IRQ_STATUS, 32'h00000000);
        rchk(mif_pkg::OFS_IRQ_MASK, 32'h00000000);
        // A refused write leaves the registers alone
        apb(1'b1, 8'h14, 32'hFFFFFFFF);
        check({31'h0, err}, 32'h00000001);
        rchk(mif_pkg::OFS_EE_LV_FLAGS, 32'h00000000);
        rchk(mif_pkg::OFS_TIMER_FLAGS, 32'h00000000);
        end_sim();
    end
endmodule
